// file: bench/lcs_sensor_model.sv
// Model of the LC sensor, comparator front end and scan clock sources
`default_nettype none
module lcs_sensor_model
	import lcs_pkg::*;
(
	input wire logic metal,
	input wire logic comparator_enable,
	input wire lcs_dac_t dac_level,
	output logic aux_clk_in,
	output logic system_sub_clock,
	output logic scan_osc_clock,
	output logic comp_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int phase;
	logic flip;
	lcs_dac_t level;
	// No external converter here: its data-ready pin and two-wire reads stay with the host
	// Oscillator taken as already trimmed, so its rate is exact
	initial
	begin
		phase = 0;
		flip = 1'b0;
		aux_clk_in = 1'b0;
		scan_osc_clock = 1'b0;
		system_sub_clock = 1'b1;
		#3;
		forever
		begin
			#80;
			scan_osc_clock = ~scan_osc_clock;
			system_sub_clock = ~system_sub_clock;
		end
	end
	// Aux rises midway between fast edges so a start never races a tick
	always @(posedge scan_osc_clock)
	begin
		phase = (phase + 1) % 80;
		aux_clk_in <= #40 (phase < 40);
		flip <= ~flip;
	end
	assign level = metal ? 12'hF00 : 12'h100;
	// A switched-off comparator holds no level: it toggles
	assign comp_in = comparator_enable ? (level > dac_level) : flip;
endmodule : lcs_sensor_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the LC scan sequencer
`include "lcs_map.svh"
`default_nettype none
module tb_top
	import lcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, metal, err_bit;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic aux_clk_in, system_sub_clock, scan_osc_clock, comp_in, excite_out;
	logic comparator_enable, dac_enable, sequence_stop, transition_flag, input_error_flag;
	logic [1:0] channel_sel, seen_sel;
	lcs_dac_t dac_level, dac_hi, dac_lo;
	logic fast_q, sub_mode, exc_seen;
	int error_cnt, total_checks, exc_ticks, cyc_ticks, dac_ticks, cmp_ticks;
	int res[2];
	int prev[2];

	lcs_sequencer dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .aux_clk_in, .system_sub_clock, .scan_osc_clock,
		.comp_in, .excite_out, .channel_sel, .comparator_enable, .dac_enable, .dac_level,
		.sequence_stop, .transition_flag, .input_error_flag);
	lcs_sensor_model model (.metal, .comparator_enable, .dac_level, .aux_clk_in,
		.system_sub_clock, .scan_osc_clock, .comp_in);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	wire fast_now = sub_mode ? system_sub_clock : scan_osc_clock;

	// Counts fast ticks under the excite pulse, the analog enables and the cycle from excitation to stop
	always @(posedge core_clk)
	begin
		fast_q <= fast_now;
		if (excite_out === 1'b1)
		begin
			seen_sel <= channel_sel;
			exc_seen <= 1'b1;
			if (fast_now && !fast_q)
				exc_ticks <= exc_ticks + 1;
		end
		if (fast_now && !fast_q)
		begin
			if ((exc_seen || excite_out === 1'b1) && sequence_stop !== 1'b1)
				cyc_ticks <= cyc_ticks + 1;
			if (dac_enable === 1'b1)
				dac_ticks <= dac_ticks + 1;
			if (comparator_enable === 1'b1)
				cmp_ticks <= cmp_ticks + 1;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	function automatic int dur_ticks(input logic [15:0] w);
		return int'(w[`LCS_DUR_MSB:`LCS_DUR_LSB]) + 1;
	endfunction : dur_ticks

	task automatic finish_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err_bit = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk("pready", 1'b0, 1'b1);
	endtask : apb

	task automatic wait_stop();
		int n;
		n = 0;
		while (sequence_stop !== 1'b1 && n < 6000)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("stop", sequence_stop, 1'b1);
	endtask : wait_stop

	task automatic run(input logic m, input logic inv, input logic ch, input logic sub);
		int cyc_exp;
		int on_exp;
		// Cleared while the stop flag still blocks counting, so no update races this
		exc_seen = 1'b0;
		cyc_ticks = 0;
		dac_ticks = 0;
		cmp_ticks = 0;
		apb(1'b1, `LCS_OFS_STATUS, 32'h7);
		apb(1'b1, 8'h20, {16'h0, 16'h5974 | {15'h0, ch}});
		apb(1'b1, 8'h24, {16'h0, 5'($urandom), 11'h200});
		apb(1'b1, `LCS_OFS_CTRL, {28'h0, inv, sub, 2'b01});
		sub_mode = sub;
		metal <= m;
		exc_ticks = 0;
		wait_stop();
		res[ch] = m ^ inv;
		chk("excite_ticks", exc_ticks, (`LCS_RST_W1 >> `LCS_DUR_LSB) + 1);
		chk("excite_channel", seen_sel, 2'h1);
		on_exp = dur_ticks(`LCS_RST_W6) + dur_ticks(`LCS_RST_W7) + dur_ticks(`LCS_RST_W8);
		cyc_exp = dur_ticks(`LCS_RST_W1) + dur_ticks(`LCS_RST_W2) + dur_ticks(`LCS_RST_W3)
			+ dur_ticks(`LCS_RST_W4) + dur_ticks(`LCS_RST_W5) + on_exp;
		// End entry adds one tick whatever its duration field holds
		chk("cycle_ticks", cyc_ticks, cyc_exp + 1);
		chk("dac_ticks", dac_ticks, on_exp);
		chk("cmp_ticks", cmp_ticks, on_exp);
		apb(1'b0, `LCS_OFS_STATUS, 32'h0);
		chk("index", rd[11:8], 4'h0);
		chk("idle", rd[4], 1'b0);
		chk("present", rd[3], res[0]);
		chk("settled", rd[6:5], 2'b11);
		chk("trans", transition_flag, res[0] != prev[0]);
		chk("error", input_error_flag, res[1] != prev[1]);
		chk("dac_level", dac_level, (res[0] ^ inv) ? dac_lo : dac_hi);
		apb(1'b1, `LCS_OFS_CTRL, 32'h0);
		prev = res;
	endtask : run

	initial
	begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		metal = 1'b0;
		sub_mode = 1'b0;
		res = '{0, 0};
		prev = '{0, 0};
		void'($urandom(95));
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, `LCS_OFS_WORDS, 32'h0);
		chk("word0", rd, 32'h0400);
		apb(1'b0, 8'h24, 32'h0);
		chk("word9", rd, 32'h0200);
		apb(1'b0, 8'h50, 32'h0);
		chk("unmapped", err_bit, 1'b1);
		// Model idle level is noise-free, so any gap above it clears the noise window
		dac_hi = 12'h400 + 12'($urandom % 2048);
		dac_lo = dac_hi - 12'($urandom % 256);
		apb(1'b1, `LCS_OFS_DAC_HI, {20'h0, dac_hi});
		apb(1'b1, `LCS_OFS_DAC_LO, {20'h0, dac_lo});
		apb(1'b0, `LCS_OFS_DAC_HI, 32'h0);
		chk("dac_hi", rd, {20'h0, dac_hi});
		apb(1'b0, `LCS_OFS_DAC_LO, 32'h0);
		chk("dac_lo", rd, {20'h0, dac_lo});
		run(1'b0, 1'b0, 1'b0, 1'b0);
		run(1'b1, 1'b0, 1'b0, 1'b1);
		run(1'b1, 1'b0, 1'b0, 1'b0);
		run(1'b1, 1'b1, 1'b0, 1'b0);
		run(1'b1, 1'b0, 1'b1, 1'b1);
		run(1'b0, 1'b0, 1'b1, 1'b0);
		apb(1'b1, `LCS_OFS_STATUS, 32'h7);
		apb(1'b1, `LCS_OFS_CTRL, 32'h3);
		wait_stop();
		apb(1'b0, `LCS_OFS_STATUS, 32'h0);
		chk("restart", rd[4], 1'b1);
		apb(1'b1, `LCS_OFS_CTRL, 32'h0);
		apb(1'b0, `LCS_OFS_STATUS, 32'h0);
		chk("abort_index", rd[11:8], 4'h0);
		finish_test();
	end

	initial
	begin
		#400us;
		error_cnt++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire

// file: hdl/lcs_dur_counter.sv
// Duration down-counter clocked by core_clk and stepped by fast-clock ticks
`default_nettype none
module lcs_dur_counter
	import lcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic load,
	input wire lcs_dur_t load_val,
	input wire logic tick,
	output logic expired,
	output lcs_dur_t count
);
	lcs_dur_t cnt_q;

	// Field value n gives n+1 ticks; not gated by load, which is derived from expiry
	assign expired = tick && (cnt_q == 5'h00);
	assign count = cnt_q;

	always_ff @(posedge core_clk)
	begin
		if (reset)
			cnt_q <= 5'h00;
		else if (load)
			cnt_q <= load_val;
		else if (tick && cnt_q != 5'h00)
			cnt_q <= cnt_q - 5'h01;
	end

	load_value_a: assert property (@(posedge core_clk) disable iff (reset)
		load |=> cnt_q == $past(load_val)) else $error("duration not loaded");
	count_step_a: assert property (@(posedge core_clk) disable iff (reset)
		(!load && tick && cnt_q != 5'h00) |=> cnt_q == $past(cnt_q) - 5'h01)
		else $error("duration count did not step");
endmodule : lcs_dur_counter
`default_nettype wire

// file: hdl/lcs_map.svh
// Register offsets, word fields, reset values and timing counts of the LC scan sequencer
// Behaviour
// - Each timed state lasts one tick more than the count held in the five top bits of its word; aux-wait and end-marker entries do not.
// - On expiry step to the next entry until an entry with the end marker.
// - Cycle end raises a stop flag, then waits for a trigger or restarts at once.
// - First entry 0x0400 waits for an auxiliary clock rising edge.
// - The end-marker entry lasts exactly one fast clock period.
// - Auxiliary, sub clock and oscillator inputs; fast timing from oscillator or sub clock.
// - Excitation entry drives a pulse on the chosen channel for its length.
// - A channel field in each word selects the excited and sampled input.
// - Per-entry bits enable comparator and DAC; settling is 3 us and 2 us.
// - An entry with latch enable captures the comparator result.
// - Two DAC level registers give the comparator hysteresis.
// - Optional comparator inversion swaps the upper and lower DAC levels.
// - Transition flag sets only on metal present/absent changes.
// - Second channel change raises the error flag, first channel change the transition flag.
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

`define LCS_NUM_STATES 10
`define LCS_OFS_WORDS 8'h00
`define LCS_OFS_CTRL 8'h40
`define LCS_OFS_DAC_HI 8'h44
`define LCS_OFS_DAC_LO 8'h48
`define LCS_OFS_STATUS 8'h4C

`define LCS_DUR_MSB 15
`define LCS_DUR_LSB 11
`define LCS_AUX_BIT 10
`define LCS_END_BIT 9
`define LCS_DAC_BIT 8
`define LCS_LATCH_BIT 6
`define LCS_CMP_BIT 4
`define LCS_EXC_BIT 3
`define LCS_CH_MSB 1

`define LCS_CTRL_EN 0
`define LCS_CTRL_AUTO 1
`define LCS_CTRL_SUBSEL 2
`define LCS_CTRL_INV 3

`define LCS_ST_STOP 0
`define LCS_ST_TRANS 1
`define LCS_ST_ERR 2
`define LCS_ST_PRESENT 3
`define LCS_ST_BUSY 4
`define LCS_ST_DAC_OK 5
`define LCS_ST_CMP_OK 6

`define LCS_RST_W0 16'h0400
`define LCS_RST_W1 16'h482D
`define LCS_RST_W2 16'h0025
`define LCS_RST_W3 16'h0025
`define LCS_RST_W4 16'h0025
`define LCS_RST_W5 16'h0025
`define LCS_RST_W6 16'hF935
`define LCS_RST_W7 16'h1935
`define LCS_RST_W8 16'h5975
`define LCS_RST_W9 16'h0200
`define LCS_RST_CTRL 4'h0
`define LCS_RST_DAC 12'h000

`define LCS_CLK_NS 10
`define LCS_DAC_SETTLE_NS 2000
`define LCS_CMP_SETTLE_NS 3000

`endif

// file: hdl/lcs_pkg.sv
// Types shared by the LC scan sequencer modules
`default_nettype none
package lcs_pkg;
	typedef logic [15:0] lcs_word_t;
	typedef logic [4:0] lcs_dur_t;
	typedef logic [11:0] lcs_dac_t;
	typedef enum logic [1:0] {
		LCS_IDLE = 2'b01,
		LCS_RUN = 2'b10
	} lcs_state_t;
endpackage : lcs_pkg
`default_nettype wire

// file: hdl/lcs_sequencer.sv
// LC scan timing and processing sequencer with APB register access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "lcs_map.svh"
`default_nettype none
module lcs_sequencer
	import lcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic aux_clk_in,
	input wire logic system_sub_clock,
	input wire logic scan_osc_clock,
	input wire logic comp_in,
	output logic excite_out,
	output logic [1:0] channel_sel,
	output logic comparator_enable,
	output logic dac_enable,
	output lcs_dac_t dac_level,
	output logic sequence_stop,
	output logic transition_flag,
	output logic input_error_flag
);
	localparam int DAC_CYC = (`LCS_DAC_SETTLE_NS + `LCS_CLK_NS - 1) / `LCS_CLK_NS;
	localparam int CMP_CYC = (`LCS_CMP_SETTLE_NS + `LCS_CLK_NS - 1) / `LCS_CLK_NS;
	localparam lcs_word_t RST_WORDS [`LCS_NUM_STATES] = '{`LCS_RST_W0, `LCS_RST_W1,
		`LCS_RST_W2, `LCS_RST_W3, `LCS_RST_W4, `LCS_RST_W5, `LCS_RST_W6,
		`LCS_RST_W7, `LCS_RST_W8, `LCS_RST_W9};

	lcs_word_t sequencer_state_regs [`LCS_NUM_STATES];
	logic [3:0] ctrl_q;
	lcs_dac_t dac_hi_q;
	lcs_dac_t dac_lo_q;
	lcs_state_t st_q;
	logic [3:0] idx_q;
	logic aux_prev_q;
	logic sub_prev_q;
	logic osc_prev_q;
	logic stop_q;
	logic trans_q;
	logic err_q;
	logic present_q;
	logic [1:0] result_q;
	logic [1:0] prev_q;
	logic excite_q;
	logic [1:0] chan_q;
	logic cmp_en_q;
	logic dac_en_q;
	lcs_dac_t dac_level_q;
	logic [8:0] settle_q;
	logic dac_ok_q;
	logic cmp_ok_q;
	logic [31:0] prdata_q;

	// APB decode, zero wait states
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire [3:0] word_idx = paddr[5:2];
	wire hit_words = (paddr[7:6] == 2'(`LCS_OFS_WORDS >> 6)) &&
		(word_idx < 4'(`LCS_NUM_STATES)) && (paddr[1:0] == 2'h0);
	wire hit_ctrl = paddr == `LCS_OFS_CTRL;
	wire hit_hi = paddr == `LCS_OFS_DAC_HI;
	wire hit_lo = paddr == `LCS_OFS_DAC_LO;
	wire hit_stat = paddr == `LCS_OFS_STATUS;
	wire hit = hit_words || hit_ctrl || hit_hi || hit_lo || hit_stat;
	wire wr = access && pwrite && hit;
	wire clr_stop = wr && hit_stat && pwdata[`LCS_ST_STOP];
	wire clr_trans = wr && hit_stat && pwdata[`LCS_ST_TRANS];
	wire clr_err = wr && hit_stat && pwdata[`LCS_ST_ERR];

	wire ctl_en = ctrl_q[`LCS_CTRL_EN];
	wire ctl_auto = ctrl_q[`LCS_CTRL_AUTO];
	wire ctl_sub = ctrl_q[`LCS_CTRL_SUBSEL];
	wire ctl_inv = ctrl_q[`LCS_CTRL_INV];

	wire [31:0] status_word = {16'h0000, 4'h0, idx_q, 1'b0, cmp_ok_q, dac_ok_q,
		st_q == LCS_RUN, present_q, err_q, trans_q, stop_q};
	wire lcs_word_t rd_word = hit_words ? sequencer_state_regs[word_idx] : 16'h0000;
	wire [31:0] rd_data = hit_words ? {16'h0000, rd_word} :
		hit_ctrl ? {28'h0000000, ctrl_q} :
		hit_hi ? {20'h00000, dac_hi_q} :
		hit_lo ? {20'h00000, dac_lo_q} :
		hit_stat ? status_word : 32'h00000000;

	assign pready = access;
	assign pslverr = access && !hit;
	assign prdata = prdata_q;

	// Inputs are synchronous; rising edges become single-cycle ticks
	wire aux_rise = aux_clk_in && !aux_prev_q;
	wire sub_rise = system_sub_clock && !sub_prev_q;
	wire osc_rise = scan_osc_clock && !osc_prev_q;
	wire scan_fast_clock = ctl_sub ? sub_rise : osc_rise;

	// Sequencer step decisions
	wire lcs_word_t cur_word = sequencer_state_regs[idx_q];
	wire running = st_q == LCS_RUN;
	wire cur_aux = cur_word[`LCS_AUX_BIT];
	wire sequence_end_marker = cur_word[`LCS_END_BIT];
	wire expired;
	wire lcs_dur_t dur_count;
	wire step_done = running && (cur_aux ? aux_rise : expired);
	// A last entry with no marker still ends the cycle, so the index never runs off
	wire final_step = step_done &&
		(sequence_end_marker || idx_q == 4'(`LCS_NUM_STATES - 1));
	wire start = (st_q == LCS_IDLE) && ctl_en && aux_rise;
	wire restart = final_step && ctl_auto && ctl_en;
	wire advance = step_done && !final_step;
	wire [3:0] nxt_idx = (start || restart) ? 4'h0 : idx_q + 4'h1;
	wire lcs_word_t nxt_word = sequencer_state_regs[nxt_idx];
	wire load = start || restart || advance;
	// End-marker entries run for one tick regardless of duration field
	wire lcs_dur_t load_val = nxt_word[`LCS_END_BIT] ? 5'h00 :
		nxt_word[`LCS_DUR_MSB:`LCS_DUR_LSB];
	wire latch_now = step_done && cur_word[`LCS_LATCH_BIT];
	wire comp_val = comp_in ^ ctl_inv;
	wire ch_change = final_step && (result_q[0] != prev_q[0]);
	wire err_change = final_step && (result_q[1] != prev_q[1]);
	// Hysteresis: inversion swaps which level serves which state
	wire lcs_dac_t dac_sel = (present_q ^ ctl_inv) ? dac_lo_q : dac_hi_q;

	lcs_dur_counter u_dur (
		.core_clk(core_clk),
		.reset(reset),
		.load(load),
		.load_val(load_val),
		.tick(scan_fast_clock),
		.expired(expired),
		.count(dur_count)
	);

	genvar g;
	generate
		for (g = 0; g < `LCS_NUM_STATES; g++)
		begin : g_word
			always_ff @(posedge core_clk)
			begin
				if (reset)
					sequencer_state_regs[g] <= RST_WORDS[g];
				else if (wr && hit_words && word_idx == 4'(g))
					sequencer_state_regs[g] <= pwdata[15:0];
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ctrl_q <= `LCS_RST_CTRL;
			dac_hi_q <= `LCS_RST_DAC;
			dac_lo_q <= `LCS_RST_DAC;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			if (wr && hit_ctrl)
				ctrl_q <= pwdata[3:0];
			if (wr && hit_hi)
				dac_hi_q <= pwdata[11:0];
			if (wr && hit_lo)
				dac_lo_q <= pwdata[11:0];
			if (setup)
				prdata_q <= rd_data;
		end
	end

	// Tracks pin levels through reset too, so release brings no false edge
	always_ff @(posedge core_clk)
	begin
		aux_prev_q <= aux_clk_in;
		sub_prev_q <= system_sub_clock;
		osc_prev_q <= scan_osc_clock;
	end

	// Timing sequencer state and index
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_q <= LCS_IDLE;
			idx_q <= 4'h0;
		end
		else
		begin
			case (st_q)
				LCS_IDLE:
					if (start)
					begin
						st_q <= LCS_RUN;
						idx_q <= 4'h0;
					end
				LCS_RUN:
					if (!ctl_en)
					begin
						st_q <= LCS_IDLE;
						idx_q <= 4'h0;
					end
					else if (final_step)
					begin
						st_q <= restart ? LCS_RUN : LCS_IDLE;
						idx_q <= 4'h0;
					end
					else if (advance)
						idx_q <= nxt_idx;
				default:
				begin
					st_q <= LCS_IDLE;
					idx_q <= 4'h0;
				end
			endcase
		end
	end

	// Front-end drive, registered from the active entry; DAC level from the hysteresis select
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			excite_q <= 1'b0;
			chan_q <= 2'h0;
			cmp_en_q <= 1'b0;
			dac_en_q <= 1'b0;
			dac_level_q <= `LCS_RST_DAC;
		end
		else
		begin
			excite_q <= running && cur_word[`LCS_EXC_BIT];
			chan_q <= running ? cur_word[`LCS_CH_MSB:0] : 2'h0;
			cmp_en_q <= running && cur_word[`LCS_CMP_BIT];
			dac_en_q <= running && cur_word[`LCS_DAC_BIT];
			dac_level_q <= dac_sel;
		end
	end

	// Settling check: counts while both analog parts are on
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			settle_q <= 9'h000;
			dac_ok_q <= 1'b0;
			cmp_ok_q <= 1'b0;
		end
		else
		begin
			if (!(cmp_en_q && dac_en_q))
				settle_q <= 9'h000;
			else if (settle_q != 9'h1FF)
				settle_q <= settle_q + 9'h001;
			if (latch_now)
			begin
				dac_ok_q <= settle_q >= 9'(DAC_CYC);
				cmp_ok_q <= settle_q >= 9'(CMP_CYC);
			end
		end
	end

	// Processing sequencer: latches, change detection and sticky flags
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			result_q <= 2'h0;
			prev_q <= 2'h0;
			present_q <= 1'b0;
			stop_q <= 1'b0;
			trans_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			if (latch_now)
				result_q[cur_word[0]] <= comp_val;
			if (final_step)
			begin
				prev_q <= result_q;
				present_q <= result_q[0];
			end
			// Hardware set beats a simultaneous software clear
			stop_q <= final_step || (stop_q && !clr_stop);
			trans_q <= ch_change || (trans_q && !clr_trans);
			err_q <= err_change || (err_q && !clr_err);
		end
	end

	assign excite_out = excite_q;
	assign channel_sel = chan_q;
	assign comparator_enable = cmp_en_q;
	assign dac_enable = dac_en_q;
	assign dac_level = dac_level_q;
	assign sequence_stop = stop_q;
	assign transition_flag = trans_q;
	assign input_error_flag = err_q;

	aux_wait_a: assert property (@(posedge core_clk) disable iff (reset)
		(running && ctl_en && cur_aux && !aux_rise) |=> idx_q == $past(idx_q))
		else $error("sync entry left without auxiliary edge");
	advance_step_a: assert property (@(posedge core_clk) disable iff (reset)
		(ctl_en && advance) |=> idx_q == $past(idx_q) + 4'h1)
		else $error("index did not advance after expiry");
	end_marker_a: assert property (@(posedge core_clk) disable iff (reset)
		(running && !cur_aux && sequence_end_marker) |->
		(dur_count == 5'h00) && (final_step == scan_fast_clock))
		else $error("end entry exceeded one fast period");
	cycle_end_a: assert property (@(posedge core_clk) disable iff (reset)
		(ctl_en && final_step) |=> (idx_q == 4'h0) && stop_q)
		else $error("cycle end did not rewind or flag stop");
	restart_mode_a: assert property (@(posedge core_clk) disable iff (reset)
		(ctl_en && final_step) |=> (st_q == LCS_RUN) == $past(ctl_auto))
		else $error("restart choice wrong after cycle end");
	excite_drive_a: assert property (@(posedge core_clk) disable iff (reset)
		(running && cur_word[`LCS_EXC_BIT]) |=> excite_out && channel_sel ==
		$past(cur_word[`LCS_CH_MSB:0])) else $error("excitation not driven");
	latch_capture_a: assert property (@(posedge core_clk) disable iff (reset)
		(latch_now && !cur_word[0]) |=> result_q[0] == $past(comp_in ^ ctl_inv))
		else $error("comparator result not latched");
	trans_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(trans_q) |-> $past(ch_change))
		else $error("transition flag set without change");
	error_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		err_change |=> err_q) else $error("second channel change missed");
	dac_swap_a: assert property (@(posedge core_clk) disable iff (reset)
		(ctl_inv && present_q && $stable(ctrl_q)) |=> dac_level == $past(dac_hi_q))
		else $error("inverted level selection wrong");
endmodule : lcs_sequencer
`default_nettype wire
